// ===== rtl/ppm_pkg.sv
// ppm_pkg: constants, codes and carriers of the parallel port pin mux
// assumes: one pclk domain, register reached over a 32-bit APB slave

package ppm_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 16;
    localparam logic [15:0] EXT_BUS_SEL_ADDR = 16'h1C00;
    localparam int          RESV_TOP_BIT    = 15;
    localparam int          ROUTE_LSB       = 12;
    localparam int          ROUTE_W         = 3;
    localparam int          ROUTE_LANE      = 1;
    localparam logic [2:0]  ROUTE_RESET     = 3'h0;

    // ------------------------------------------------------------------
    // pin count and route codes
    // ------------------------------------------------------------------
    localparam int          PIN_N           = 21;
    localparam int          LCD8_N          = 8;
    localparam logic [2:0]  ROUTE_LCD16     = 3'h0;
    localparam logic [2:0]  ROUTE_SPI_MIX   = 3'h1;
    localparam logic [2:0]  ROUTE_LCD_GPIO  = 3'h2;
    localparam logic [2:0]  ROUTE_LCD_SPI_B = 3'h3;
    localparam logic [2:0]  ROUTE_LCD_A_UART = 3'h4;
    localparam logic [2:0]  ROUTE_LCD_SPI_U = 3'h5;
    localparam logic [2:0]  ROUTE_CODE_6    = 3'h6;
    localparam logic [2:0]  ROUTE_CODE_7    = 3'h7;
    localparam logic [2:0]  ROUTE_PARK      = 3'h7;

    // ------------------------------------------------------------------
    // peripheral source codes
    // ------------------------------------------------------------------
    localparam int          SRC_N           = 7;
    localparam logic [2:0]  SRC_NONE        = 3'h0;
    localparam logic [2:0]  SRC_LCD         = 3'h1;
    localparam logic [2:0]  SRC_SPI         = 3'h2;
    localparam logic [2:0]  SRC_UART        = 3'h3;
    localparam logic [2:0]  SRC_GPIO        = 3'h4;
    localparam logic [2:0]  SRC_AUD_A       = 3'h5;
    localparam logic [2:0]  SRC_AUD_B       = 3'h6;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [PIN_N-1:0] dout;
        logic [PIN_N-1:0] oe;
    } ppm_drive_s;

    typedef struct packed {
        logic [2:0] src;
        logic [4:0] idx;
    } ppm_slot_s;

endpackage : ppm_pkg

// ===== rtl/ppm_route.sv
// ppm_route: combinational pin map for one route code
// assumes: inputs already in pclk domain, caller registers the outputs

`timescale 1ns/10ps

module ppm_route
(
    // route selection
    input  wire logic [2:0]                                route,
    // peripheral drive and pin level
    input  wire ppm_pkg::ppm_drive_s [ppm_pkg::SRC_N-1:0]  src,
    input  wire logic [ppm_pkg::PIN_N-1:0]                 pin_level,
    // pin drive and peripheral receive
    output ppm_pkg::ppm_drive_s                            pin_drv,
    output logic [ppm_pkg::SRC_N-1:0][ppm_pkg::PIN_N-1:0]  rx
);

    // ------------------------------------------------------------------
    // slot helpers
    // ------------------------------------------------------------------
    function automatic ppm_pkg::ppm_slot_s slot(input logic [2:0] s,
                                                input int         i);
        ppm_pkg::ppm_slot_s r;
        r.src = s;
        r.idx = 5'(i);
        return r;
    endfunction : slot

    // eight pixel bits, then two groups of four
    function automatic ppm_pkg::ppm_slot_s lcd8(input int         p,
                                                input logic [2:0] a,
                                                input logic [2:0] b);
        ppm_pkg::ppm_slot_s r;
        r = slot(ppm_pkg::SRC_NONE, 0);
        if (p < 8)
            r = slot(ppm_pkg::SRC_LCD, p);
        else if (p < 12)
            r = slot(a, p - 8);
        else if (p < 16)
            r = slot(b, p - 12);
        return r;
    endfunction : lcd8

    // source and bit that own pin p under code c
    function automatic ppm_pkg::ppm_slot_s pin_map(input logic [2:0] c,
                                                   input int         p);
        ppm_pkg::ppm_slot_s r;
        r = slot(ppm_pkg::SRC_NONE, 0);
        case (c)
            ppm_pkg::ROUTE_LCD16:
                r = slot(ppm_pkg::SRC_LCD, p); // [RULE3]
            ppm_pkg::ROUTE_SPI_MIX:
            begin
                if (p < 7)
                    r = slot(ppm_pkg::SRC_SPI, p); // [RULE4]
                else if (p < 13)
                    r = slot(ppm_pkg::SRC_GPIO, p - 7);
                else if (p < 17)
                    r = slot(ppm_pkg::SRC_UART, p - 13);
                else
                    r = slot(ppm_pkg::SRC_AUD_A, p - 17);
            end
            ppm_pkg::ROUTE_LCD_GPIO:
                r = lcd8(p, ppm_pkg::SRC_GPIO, ppm_pkg::SRC_GPIO); // [RULE5]
            ppm_pkg::ROUTE_LCD_SPI_B:
                r = lcd8(p, ppm_pkg::SRC_SPI, ppm_pkg::SRC_AUD_B); // [RULE6]
            ppm_pkg::ROUTE_LCD_A_UART:
                r = lcd8(p, ppm_pkg::SRC_AUD_A, ppm_pkg::SRC_UART); // [RULE7]
            ppm_pkg::ROUTE_LCD_SPI_U:
                r = lcd8(p, ppm_pkg::SRC_SPI, ppm_pkg::SRC_UART); // [RULE8]
            default:
                r = slot(ppm_pkg::SRC_NONE, 0);
        endcase
        // gpio group in the pixel code is eight wide
        if (c == ppm_pkg::ROUTE_LCD_GPIO && p >= 8 && p < 16)
            r = slot(ppm_pkg::SRC_GPIO, p - 8);
        return r;
    endfunction : pin_map

    // ------------------------------------------------------------------
    // per-pin selection in both directions
    // ------------------------------------------------------------------
    ppm_pkg::ppm_slot_s m;

    always_comb
    begin
        pin_drv = '0;
        rx      = '0;
        m       = '0;
        for (int p = 0; p < ppm_pkg::PIN_N; p++)
        begin
            m = pin_map(route, p);
            if (m.src != ppm_pkg::SRC_NONE)
            begin
                pin_drv.dout[p]  = src[m.src].dout[m.idx];
                pin_drv.oe[p]    = src[m.src].oe[m.idx];
                rx[m.src][m.idx] = pin_level[p];
            end
        end
    end

endmodule : ppm_route

// ===== rtl/ppm_pin_mux.sv
// ppm_pin_mux: parallel port pin mux with its bus selection register
// assumes: APB master on pclk, peripherals on pclk, pins asynchronous
//
// Overview of operation
// [RULE1] bit 15 reads zero, writes ignored
// [RULE2] bits 14:12 select the pin sharing
// [RULE3] code 000 gives all 21 lcd lines
// [RULE4] code 001: spi7, gpio6, uart4, audio a4
// [RULE5] code 010: lcd pixel8 and gpio8
// [RULE6] code 011: lcd pixel8, spi4, audio b4
// [RULE7] code 100: lcd pixel8, audio a4, uart4
// [RULE8] code 101: lcd pixel8, spi4, uart4
// [RULE9] new routing effective next clock cycle
// [RULE10] fixed address, route field resets to 000
// [RULE11] software gates and resets peripherals around change
// [RULE12] codes 110 and 111 routing is parameterised
//
// Our own choices: register access over APB and the register offsets.

`timescale 1ns/10ps

module ppm_pin_mux
#(
    parameter logic [2:0] CODE6_ROUTE = ppm_pkg::ROUTE_PARK,
    parameter logic [2:0] CODE7_ROUTE = ppm_pkg::ROUTE_PARK
)
(
    // clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ppm_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // peripheral drive
    input  wire ppm_pkg::ppm_drive_s         lcd_drv,
    input  wire ppm_pkg::ppm_drive_s         spi_drv,
    input  wire ppm_pkg::ppm_drive_s         uart_drv,
    input  wire ppm_pkg::ppm_drive_s         port_gpio_lines_drv,
    input  wire ppm_pkg::ppm_drive_s         extra_audio_port_a_drv,
    input  wire ppm_pkg::ppm_drive_s         extra_audio_port_b_drv,
    // peripheral receive
    output logic [ppm_pkg::PIN_N-1:0]        lcd_rx,
    output logic [ppm_pkg::PIN_N-1:0]        spi_rx,
    output logic [ppm_pkg::PIN_N-1:0]        uart_rx,
    output logic [ppm_pkg::PIN_N-1:0]        port_gpio_lines_rx,
    output logic [ppm_pkg::PIN_N-1:0]        extra_audio_port_a_rx,
    output logic [ppm_pkg::PIN_N-1:0]        extra_audio_port_b_rx,
    // parallel port pins
    input  wire logic [ppm_pkg::PIN_N-1:0]   pin_in,
    output logic      [ppm_pkg::PIN_N-1:0]   pin_out,
    output logic      [ppm_pkg::PIN_N-1:0]   pin_oe
);

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic [2:0]  parallel_port_route_field;
    logic [2:0]  next_route_field;
    logic [2:0]  next_route;
    logic [31:0] rd_word;
    wire         addr_hit;
    wire         setup_phase;
    wire         wr_commit;

    // setup phase answers in the following access cycle
    assign addr_hit    = (paddr == ppm_pkg::EXT_BUS_SEL_ADDR); // [RULE10]
    assign setup_phase = psel & ~penable;
    assign wr_commit   = psel & penable & pready & pwrite & addr_hit
                       & pstrb[ppm_pkg::ROUTE_LANE];

    // only the route field is stored; bit 15 never stored
    assign next_route_field = wr_commit
        ? pwdata[ppm_pkg::ROUTE_LSB +: ppm_pkg::ROUTE_W] // [RULE2]
        : parallel_port_route_field;

    // readback: top bit and unused bits zero
    always_comb
    begin
        rd_word = '0; // [RULE1]
        rd_word[ppm_pkg::ROUTE_LSB +: ppm_pkg::ROUTE_W] =
            parallel_port_route_field;
    end

    // unlisted codes follow the parameters
    assign next_route =
        (next_route_field == ppm_pkg::ROUTE_CODE_6) ? CODE6_ROUTE : // [RULE12]
        (next_route_field == ppm_pkg::ROUTE_CODE_7) ? CODE7_ROUTE :
        next_route_field;

    // ------------------------------------------------------------------
    // bus selection register
    // ------------------------------------------------------------------
    // route field, reset to lcd16
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            parallel_port_route_field <= ppm_pkg::ROUTE_RESET; // [RULE10]
        else
            parallel_port_route_field <= next_route_field;
    end

    // apb answer, one wait-free access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
        else
        begin
            pready  <= setup_phase;
            pslverr <= setup_phase & ~addr_hit;
            prdata  <= (setup_phase & ~pwrite & addr_hit) ? rd_word : '0;
        end
    end

    // ------------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------------
    logic [ppm_pkg::PIN_N-1:0] pin_meta;
    logic [ppm_pkg::PIN_N-1:0] pin_sync;

    // two stages before any logic looks at the pins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
        end
        else
        begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

    // ------------------------------------------------------------------
    // routing
    // ------------------------------------------------------------------
    ppm_pkg::ppm_drive_s [ppm_pkg::SRC_N-1:0]          src_all;
    ppm_pkg::ppm_drive_s                               pin_drv;
    logic [ppm_pkg::SRC_N-1:0][ppm_pkg::PIN_N-1:0]     rx_all;

    // sources indexed by their code, slot zero idle
    assign src_all[ppm_pkg::SRC_NONE]  = '0;
    assign src_all[ppm_pkg::SRC_LCD]   = lcd_drv;
    assign src_all[ppm_pkg::SRC_SPI]   = spi_drv;
    assign src_all[ppm_pkg::SRC_UART]  = uart_drv;
    assign src_all[ppm_pkg::SRC_GPIO]  = port_gpio_lines_drv;
    assign src_all[ppm_pkg::SRC_AUD_A] = extra_audio_port_a_drv;
    assign src_all[ppm_pkg::SRC_AUD_B] = extra_audio_port_b_drv;

    ppm_route u_route
    (
        .route     (next_route),
        .src       (src_all),
        .pin_level (pin_sync),
        .pin_drv   (pin_drv),
        .rx        (rx_all)
    );

    // new code drives the pins from the write edge on
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out <= '0;
            pin_oe  <= '0;
        end
        else
        begin
            pin_out <= pin_drv.dout; // [RULE9]
            pin_oe  <= pin_drv.oe;
        end
    end

    // received levels back to each peripheral
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lcd_rx                <= '0;
            spi_rx                <= '0;
            uart_rx               <= '0;
            port_gpio_lines_rx    <= '0;
            extra_audio_port_a_rx <= '0;
            extra_audio_port_b_rx <= '0;
        end
        else
        begin
            lcd_rx                <= rx_all[ppm_pkg::SRC_LCD];
            spi_rx                <= rx_all[ppm_pkg::SRC_SPI];
            uart_rx               <= rx_all[ppm_pkg::SRC_UART];
            port_gpio_lines_rx    <= rx_all[ppm_pkg::SRC_GPIO];
            extra_audio_port_a_rx <= rx_all[ppm_pkg::SRC_AUD_A];
            extra_audio_port_b_rx <= rx_all[ppm_pkg::SRC_AUD_B];
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    logic was_up;

    // marks cycles after the first one out of reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            was_up <= 1'b0;
        else
            was_up <= 1'b1;
    end

    wire rd_done = psel & penable & pready & ~pwrite;
    wire wr_done = psel & penable & pready & pwrite & addr_hit;
    wire [2:0] fld = parallel_port_route_field;

    a_top_bit_zero: assert property ( // [RULE1]
        @(posedge pclk) disable iff (!presetn)
        rd_done && addr_hit |-> prdata[15] == 1'b0 && prdata[31:16] == '0)
        else $error("top bit of select register not zero");

    a_field_written: assert property ( // [RULE2]
        @(posedge pclk) disable iff (!presetn)
        wr_done && pstrb[1] |=> fld == $past(pwdata[14:12]))
        else $error("route field did not take written value");

    a_field_readback: assert property ( // [RULE2]
        @(posedge pclk) disable iff (!presetn)
        rd_done && addr_hit |-> prdata[14:12] == fld)
        else $error("route field readback wrong");

    a_lcd16_route: assert property ( // [RULE3]
        @(posedge pclk) disable iff (!presetn)
        was_up && fld == 3'h0 |->
            pin_out == $past(lcd_drv.dout) && pin_oe == $past(lcd_drv.oe))
        else $error("lcd16 routing wrong");

    a_spi_mix_route: assert property ( // [RULE4]
        @(posedge pclk) disable iff (!presetn)
        was_up && fld == 3'h1 |->
            pin_out[6:0] == $past(spi_drv.dout[6:0])
            && pin_out[12:7] == $past(port_gpio_lines_drv.dout[5:0])
            && pin_out[16:13] == $past(uart_drv.dout[3:0])
            && pin_oe[20:17] == $past(extra_audio_port_a_drv.oe[3:0]))
        else $error("spi mix routing wrong");

    a_lcd_gpio_route: assert property ( // [RULE5]
        @(posedge pclk) disable iff (!presetn)
        was_up && fld == 3'h2 |->
            pin_out[15:8] == $past(port_gpio_lines_drv.dout[7:0])
            && pin_oe[20:16] == '0)
        else $error("lcd gpio routing wrong");

    a_lcd_spi_b_route: assert property ( // [RULE6]
        @(posedge pclk) disable iff (!presetn)
        was_up && fld == 3'h3 |->
            pin_out[11:8] == $past(spi_drv.dout[3:0])
            && pin_out[15:12] == $past(extra_audio_port_b_drv.dout[3:0]))
        else $error("lcd spi audio b routing wrong");

    a_lcd_a_uart_route: assert property ( // [RULE7]
        @(posedge pclk) disable iff (!presetn)
        was_up && fld == 3'h4 |->
            pin_out[11:8] == $past(extra_audio_port_a_drv.dout[3:0])
            && pin_oe[15:12] == $past(uart_drv.oe[3:0]))
        else $error("lcd audio a uart routing wrong");

    a_lcd_spi_u_route: assert property ( // [RULE8]
        @(posedge pclk) disable iff (!presetn)
        was_up && fld == 3'h5 |->
            pin_out[7:0] == $past(lcd_drv.dout[7:0])
            && pin_out[15:12] == $past(uart_drv.dout[3:0]))
        else $error("lcd spi uart routing wrong");

    a_route_latency: assert property ( // [RULE9]
        @(posedge pclk) disable iff (!presetn)
        wr_done && pstrb[1] && pwdata[14:12] == 3'h2 |=> pin_oe[20:16] == '0)
        else $error("new routing late");

    a_unmapped_error: assert property ( // [RULE10]
        @(posedge pclk) disable iff (!presetn)
        setup_phase && !addr_hit |=> pready && pslverr && prdata == '0)
        else $error("unmapped access not refused");

    a_park_code: assert property ( // [RULE12]
        @(posedge pclk) disable iff (!presetn)
        fld == 3'h7 && CODE7_ROUTE == 3'h7 |-> pin_oe == '0)
        else $error("parked code drives pins");

    c_write_lcd16: cover property (
        @(posedge pclk) disable iff (!presetn)
        wr_done && pwdata[14:12] == 3'h0);

    c_write_spi_mix: cover property (
        @(posedge pclk) disable iff (!presetn)
        wr_done && pwdata[14:12] == 3'h1);

    c_read_back: cover property (
        @(posedge pclk) disable iff (!presetn)
        rd_done && addr_hit);

    c_unmapped: cover property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pslverr);

endmodule : ppm_pin_mux

// ===== testbench/ppm_pin_model.sv
// ppm_pin_model: board side of the 21 parallel port pins
// assumes: bench gives the external drive level of every pin

`timescale 1ns/10ps

module ppm_pin_model
(
    // pin drive from the device
    input  wire logic [ppm_pkg::PIN_N-1:0] pin_out,
    input  wire logic [ppm_pkg::PIN_N-1:0] pin_oe,
    // external device level
    input  wire logic [ppm_pkg::PIN_N-1:0] ext_val,
    // resolved pin level back to the device
    output logic      [ppm_pkg::PIN_N-1:0] pin_in
);

    // device wins where it drives, the board drives the rest
    assign pin_in = (pin_out & pin_oe) | (ext_val & ~pin_oe);

endmodule : ppm_pin_model

// ===== testbench/testbench.sv
// testbench: self-checking bench of the parallel port pin mux
// assumes: apb master in this module, pin model on the far side

`timescale 1ns/10ps

module testbench;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic                       pclk;
    logic                       presetn;
    logic                       psel;
    logic                       penable;
    logic                       pwrite;
    logic [15:0]                paddr;
    logic [31:0]                pwdata;
    logic [3:0]                 pstrb;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    ppm_pkg::ppm_drive_s        drv [7];
    logic [20:0]                rx_a [7];
    logic [20:0]                pin_in;
    logic [20:0]                pin_out;
    logic [20:0]                pin_oe;
    logic [20:0]                ext_val;
    logic [31:0]                rd;
    logic                       err;
    int                         bad_count;
    int                         tests_run;
    int                         cyc;

    // ------------------------------------------------------------------
    // design, pin model, clock
    // ------------------------------------------------------------------
    ppm_pin_mux DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lcd_drv(drv[1]), .spi_drv(drv[2]), .uart_drv(drv[3]),
        .port_gpio_lines_drv(drv[4]), .extra_audio_port_a_drv(drv[5]),
        .extra_audio_port_b_drv(drv[6]), .lcd_rx(rx_a[1]), .spi_rx(rx_a[2]),
        .uart_rx(rx_a[3]), .port_gpio_lines_rx(rx_a[4]),
        .extra_audio_port_a_rx(rx_a[5]), .extra_audio_port_b_rx(rx_a[6]),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

    ppm_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_val(ext_val), .pin_in(pin_in));

    // free running 50 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // hang guard
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            summarize();
        end
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // expected pin to source map of one route code
    function automatic ppm_pkg::ppm_slot_s slot(input logic [2:0] m,
                                                input int p);
        logic [2:0] s;
        int         i;
        s = ppm_pkg::SRC_NONE;
        i = 0;
        if (m == 3'h0) begin s = ppm_pkg::SRC_LCD; i = p; end
        else if (m == 3'h1)
        begin
            if (p < 7) begin s = ppm_pkg::SRC_SPI; i = p; end
            else if (p < 13) begin s = ppm_pkg::SRC_GPIO; i = p - 7; end
            else if (p < 17) begin s = ppm_pkg::SRC_UART; i = p - 13; end
            else begin s = ppm_pkg::SRC_AUD_A; i = p - 17; end
        end
        else if (m < 3'h6 && p < 8) begin s = ppm_pkg::SRC_LCD; i = p; end
        else if (m == 3'h2 && p < 16) begin s = ppm_pkg::SRC_GPIO; i = p-8; end
        else if (m < 3'h6 && p < 12)
        begin
            i = p - 8;
            s = (m == 3'h4) ? ppm_pkg::SRC_AUD_A : ppm_pkg::SRC_SPI;
        end
        else if (m > 3'h2 && m < 3'h6 && p < 16)
        begin
            i = p - 12;
            s = (m == 3'h3) ? ppm_pkg::SRC_AUD_B : ppm_pkg::SRC_UART;
        end
        slot.src = s;
        slot.idx = 5'(i);
    endfunction : slot

    // one comparison, counted
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        tests_run++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
            bad_count++;
        end
    endtask : chk

    // one apb transfer, waits for pready
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    // compare every pin with the expected map
    task automatic check_pins(input logic [2:0] m);
        ppm_pkg::ppm_slot_s sl;
        logic               eo;
        logic               ee;
        for (int p = 0; p < 21; p++)
        begin
            sl = slot(m, p);
            eo = (sl.src == 0) ? 1'b0 : drv[sl.src].dout[sl.idx];
            ee = (sl.src == 0) ? 1'b0 : drv[sl.src].oe[sl.idx];
            chk({31'h0, pin_out[p]}, {31'h0, eo}, "pin out");
            chk({31'h0, pin_oe[p]}, {31'h0, ee}, "pin oe");
        end
    endtask : check_pins

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // reset state of register and pins
    task automatic t_reset();
        apb(1'b0, ppm_pkg::EXT_BUS_SEL_ADDR, 32'h0, 4'hF);
        chk(rd, 32'h0000_0000, "reset value");
        check_pins(3'h0);
    endtask : t_reset

    // every documented code, peripheral drive held constant around the change
    task automatic t_modes();
        for (int m = 5; m >= 0; m--)
        begin
            apb(1'b1, ppm_pkg::EXT_BUS_SEL_ADDR, 32'(m) << 12, 4'hF);
            check_pins(3'(m));
            apb(1'b0, ppm_pkg::EXT_BUS_SEL_ADDR, 32'h0, 4'hF);
            chk(rd, 32'(m) << 12, "mode readback");
        end
    endtask : t_modes

    // top bit set together with a route code
    task automatic t_top_bit();
        apb(1'b1, ppm_pkg::EXT_BUS_SEL_ADDR, 32'hFFFF_DFFF, 4'hF);
        apb(1'b0, ppm_pkg::EXT_BUS_SEL_ADDR, 32'h0, 4'hF);
        chk(rd, 32'h0000_5000, "top bit readback");
        check_pins(3'h5);
    endtask : t_top_bit

    // wrong address and masked byte lane change nothing
    task automatic t_refused();
        apb(1'b1, 16'h1C04, 32'h0000_2000, 4'hF);
        chk({31'h0, err}, 32'h1, "slverr");
        apb(1'b1, ppm_pkg::EXT_BUS_SEL_ADDR, 32'h0000_2000, 4'hD);
        apb(1'b0, ppm_pkg::EXT_BUS_SEL_ADDR, 32'h0, 4'hF);
        chk(rd, 32'h0000_5000, "refused write");
        chk({31'h0, err}, 32'h0, "no slverr");
        check_pins(3'h5);
    endtask : t_refused

    // codes without a known map park the pins
    task automatic t_park();
        for (int m = 6; m < 8; m++)
        begin
            apb(1'b1, ppm_pkg::EXT_BUS_SEL_ADDR, 32'(m) << 12, 4'h2);
            check_pins(3'(m));
            apb(1'b0, ppm_pkg::EXT_BUS_SEL_ADDR, 32'h0, 4'hF);
            chk(rd, 32'(m) << 12, "park readback");
        end
    endtask : t_park

    // pin levels back to peripherals, and drive latency
    task automatic t_receive();
        logic [20:0] exp [7];
        ppm_pkg::ppm_slot_s sl;
        apb(1'b1, ppm_pkg::EXT_BUS_SEL_ADDR, 32'h0000_2000, 4'hF);
        @(posedge pclk);
        ext_val <= 21'h0C3A5E;
        repeat (5) @(posedge pclk);
        #1;
        for (int s = 0; s < 7; s++) exp[s] = 21'h0;
        for (int p = 0; p < 21; p++)
        begin
            sl = slot(3'h2, p);
            if (sl.src != 0)
                exp[sl.src][sl.idx] = pin_oe[p] ? pin_out[p] : ext_val[p];
        end
        for (int s = 1; s < 7; s++)
            chk({11'h0, rx_a[s]}, {11'h0, exp[s]}, "rx");
        @(posedge pclk);
        drv[1].dout <= ~drv[1].dout;
        @(posedge pclk);
        #1;
        check_pins(3'h2);
    endtask : t_receive

    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 16'h0;
        pwdata  = 32'h0;
        pstrb   = 4'h0;
        ext_val = 21'h15A5A5;
        for (int s = 0; s < 7; s++)
        begin
            drv[s].dout = 21'h15A5A5 ^ 21'(s * 21'h0F0F1);
            drv[s].oe   = 21'h0E38E3 ^ 21'(s * 21'h13579);
        end
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_modes();
        t_top_bit();
        t_refused();
        t_park();
        t_receive();
        summarize();
    end

endmodule : testbench
